/* sim/ocs_line_card.sv */
// Purpose: Line card model that consumes the sync pins
// Assumes: Sync pins are sampled on clk_sys
// Notes: Counts rising edges so the bench can check pulse rates
`timescale 1ns/1ns
module ocs_line_card (
  input wire logic clk_sys, // System clock
  input wire logic frame_sync_pin, // 8 kHz sync in
  input wire logic multiframe_sync_pin, // 2 kHz sync in
  output logic [7:0] fs_edges, // Frame sync rising edges
  output logic [7:0] mfs_edges // Multiframe sync rising edges
);
  logic fs_q = 1'b0;
  logic mfs_q = 1'b0;
  logic [7:0] fs_cnt = 8'h00;
  logic [7:0] mfs_cnt = 8'h00;
  always_ff @(posedge clk_sys) begin
    fs_q <= frame_sync_pin;
    mfs_q <= multiframe_sync_pin;
    fs_cnt <= fs_cnt + {7'h00, frame_sync_pin & ~fs_q};
    mfs_cnt <= mfs_cnt + {7'h00, multiframe_sync_pin & ~mfs_q};
  end
  assign fs_edges = fs_cnt;
  assign mfs_edges = mfs_cnt;
endmodule // ocs_line_card

/* sim/ocs_top_bench.sv */
// Purpose: Self-checking bench for the output clock rate select block
// Assumes: Straps fixed at 5 for A and 2 for B
// Notes: Sync ticks have periods of 8 and 32 cycles
`timescale 1ns/1ns
module ocs_top_bench;
  import ocs_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [4:0] tick_cnt = 5'h00;
  logic auto_bw = 1'b0;
  logic [2:0] acq_bw = 3'h0;
  logic acquiring = 1'b0;
  ocs_sel_type out_a;
  ocs_sel_type out_b;
  ocs_rate_type aux_rate;
  ocs_rate_type main_rate;
  logic fs_pin;
  logic mfs_pin;
  logic measure;
  logic [8:0] aux_bw_hz;
  logic [8:0] main_bw_hz;
  logic [7:0] fs_edges;
  logic [7:0] mfs_edges;
  int fail_count = 0;
  int samples_checked = 0;
  initial forever #2 clk_sys = ~clk_sys;
  always @(negedge clk_sys) tick_cnt <= tick_cnt + 5'h01;
  ocs_top ocs_top_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .output_a_default_strap(3'h5), .output_b_default_strap(3'h2),
    .frame_tick_8k(tick_cnt[2]), .multiframe_tick_2k(tick_cnt[4]),
    .auto_bandwidth_switch(auto_bw), .main_acquisition_bandwidth(acq_bw),
    .main_acquiring(acquiring), .output_clock_a(out_a), .output_clock_b(out_b),
    .frame_sync_pin(fs_pin), .multiframe_sync_pin(mfs_pin), .aux_apll_rate(aux_rate),
    .main_apll_rate(main_rate), .aux_measures_main_phase(measure),
    .aux_dpll_bw_hz(aux_bw_hz), .main_dpll_bw_hz(main_bw_hz));
  ocs_line_card ocs_line_card_inst (.clk_sys(clk_sys), .frame_sync_pin(fs_pin),
    .multiframe_sync_pin(mfs_pin), .fs_edges(fs_edges), .mfs_edges(mfs_edges));
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    check({32'h0, reg_rdata}, {32'h0, exp});
  endtask
  task automatic t_reset();
    rd(8'h61, 8'h05);
    rd(8'h62, 8'h20);
    rd(8'h63, 8'hC0);
    rd(8'h64, 8'h02);
    rd(8'h65, 8'h05);
    rd(8'h66, 8'h00);
    rd(8'h67, 8'h00);
    rd(8'h4F, 8'h00);
    rd(8'h60, 8'h00);
    check(main_rate, {RATE_24M704, RATE_24M704 * APLL_MULT});
  endtask
  task automatic t_out_a();
    wr(8'h61, 8'h05);
    check({29'h0, out_a}, {29'h0, OC_MAIN, 7'h30});
    wr(8'h61, 8'hFF);
    rd(8'h61, 8'h0F);
    check({29'h0, out_a}, {29'h0, OC_AUX, 7'h04});
    wr(8'h61, 8'h00);
    check({29'h0, out_a}, {29'h0, OC_OFF, 7'h00});
    wr(8'h4F, 8'hFF);
    rd(8'h4F, 8'h24);
    wr(8'h61, 8'h01);
    check({29'h0, out_a}, {29'h0, OC_MAIN, 7'h40});
    wr(8'h61, 8'h08);
    check({29'h0, out_a}, {29'h0, OC_OFF, 7'h00});
  endtask
  task automatic t_out_b();
    wr(8'h62, 8'h60);
    check({29'h0, out_b}, {29'h0, OC_MAIN_SECOND, 7'h01});
    wr(8'h4F, 8'h00);
    wr(8'h62, 8'h30);
    check({29'h0, out_b}, {29'h0, OC_MAIN, 7'h02});
    wr(8'h62, 8'h50);
    check({29'h0, out_b}, {29'h0, OC_MAIN, 7'h01});
  endtask
  task automatic t_rates();
    wr(8'h64, 8'h0C);
    check(aux_rate, {RATE_26M000, RATE_26M000 * APLL_MULT});
    wr(8'h64, 8'h0D);
    check(aux_rate, 40'h0);
    wr(8'h65, 8'hC8);
    check(aux_rate, {RATE_62M500, RATE_62M500 * APLL_MULT});
    check(main_rate, {RATE_77M760, RATE_77M760 * APLL_MULT});
    check({39'h0, measure}, 40'h1);
    wr(8'h65, 8'h58);
    check(aux_rate, 40'h0);
    check({39'h0, measure}, 40'h0);
  endtask
  task automatic t_bw();
    wr(8'h66, 8'h02);
    check({31'h0, aux_bw_hz}, {31'h0, BW_70HZ});
    wr(8'h66, 8'h03);
    check({31'h0, aux_bw_hz}, 40'h0);
    wr(8'h67, 8'h1C);
    rd(8'h67, 8'h1C);
    check({31'h0, main_bw_hz}, {31'h0, BW_120HZ});
    auto_bw = 1'b1;
    acquiring = 1'b1;
    acq_bw = 3'h6;
    repeat (3) @(negedge clk_sys);
    check({31'h0, main_bw_hz}, {31'h0, BW_400HZ});
    acquiring = 1'b0;
    repeat (3) @(negedge clk_sys);
    check({31'h0, main_bw_hz}, {31'h0, BW_120HZ});
  endtask
  task automatic t_sync(input logic [7:0] en, input logic [7:0] nf, input logic [7:0] nm);
    logic [7:0] f0;
    logic [7:0] m0;
    wr(8'h63, en);
    repeat (4) @(negedge clk_sys);
    f0 = fs_edges;
    m0 = mfs_edges;
    repeat (64) @(negedge clk_sys);
    check({32'h0, fs_edges - f0}, {32'h0, nf});
    check({32'h0, mfs_edges - m0}, {32'h0, nm});
  endtask
  task automatic print_verdict();
    $display("checked=%0d errors=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial begin
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    t_reset();
    t_out_a();
    t_out_b();
    t_rates();
    t_bw();
    t_sync(8'hC0, 8'h08, 8'h02);
    t_sync(8'h00, 8'h00, 8'h00);
    print_verdict();
  end
endmodule // ocs_top_bench

/* verilog/ocs_pkg.sv */
// Purpose: Shared constants and types for the output clock rate select block
// Assumes: Byte-wide register port, 8-bit offsets, rates carried in kHz
// Notes: Unused or undefined codes decode to zero rate or to a held-low output

package ocs_pkg;

  localparam int STRAP_WIDTH = 3;

  // Register offsets
  localparam logic [7:0] ADDR_ALT_DECODE = 8'h4F;
  localparam logic [7:0] ADDR_OUT_A_SEL = 8'h61;
  localparam logic [7:0] ADDR_OUT_B_SEL = 8'h62;
  localparam logic [7:0] ADDR_SYNC_EN = 8'h63;
  localparam logic [7:0] ADDR_AUX_RATE = 8'h64;
  localparam logic [7:0] ADDR_MAIN_RATE = 8'h65;
  localparam logic [7:0] ADDR_AUX_BW = 8'h66;
  localparam logic [7:0] ADDR_LOCKED_BW = 8'h67;

  // Field positions
  localparam int ALT_A_BIT = 2;
  localparam int ALT_B_BIT = 5;
  localparam int OUT_B_LSB = 4;
  localparam int FS_EN_BIT = 6;
  localparam int MFS_EN_BIT = 7;
  localparam int FT4_LSB = 3;
  localparam int AUX_SRC_BIT = 6;
  localparam int MEASURE_BIT = 7;
  localparam int SPARE_ONE_BIT = 4;
  localparam int SPARE_TWO_BIT = 3;

  // Reset values
  localparam logic [7:0] SYNC_EN_RESET = 8'hC0;
  localparam logic [1:0] AUX_BW_RESET = 2'h0;
  localparam logic [2:0] LOCKED_BW_RESET = 3'h0;
  localparam logic [2:0] FT4_RESET = 3'h0;
  localparam logic ALT_RESET = 1'b0;
  localparam logic FLAG_RESET = 1'b0;

  // Synthesis rates in kHz
  localparam logic [19:0] RATE_OFF = 20'h0;
  localparam logic [19:0] RATE_77M760 = 20'h12FC0;
  localparam logic [19:0] RATE_24M576 = 20'h06000;
  localparam logic [19:0] RATE_32M768 = 20'h08000;
  localparam logic [19:0] RATE_37M056 = 20'h090C0;
  localparam logic [19:0] RATE_24M704 = 20'h06080;
  localparam logic [19:0] RATE_68M736 = 20'h10C80;
  localparam logic [19:0] RATE_44M736 = 20'h0AEC0;
  localparam logic [19:0] RATE_25M248 = 20'h062A0;
  localparam logic [19:0] RATE_62M500 = 20'h0F424;
  localparam logic [19:0] RATE_30M720 = 20'h07800;
  localparam logic [19:0] RATE_40M000 = 20'h09C40;
  localparam logic [19:0] RATE_26M000 = 20'h06590;
  localparam logic [19:0] APLL_MULT = 20'h4;

  // Loop bandwidths in Hz
  localparam logic [8:0] BW_NONE = 9'h0;
  localparam logic [8:0] BW_18HZ = 9'h012;
  localparam logic [8:0] BW_35HZ = 9'h023;
  localparam logic [8:0] BW_70HZ = 9'h046;
  localparam logic [8:0] BW_120HZ = 9'h078;
  localparam logic [8:0] BW_250HZ = 9'h0FA;
  localparam logic [8:0] BW_400HZ = 9'h190;

  typedef enum logic [3:0] {
    OC_OFF, OC_2K, OC_8K, OC_DIG_TWO, OC_DIG_ONE, OC_MAIN, OC_AUX, OC_MAIN_SECOND, OC_AUX_REF
  } ocs_src_type;

  typedef struct packed {
    ocs_src_type src;
    logic [6:0] div;
  } ocs_sel_type;

  typedef struct packed {
    logic [19:0] dfs_khz;
    logic [19:0] apll_khz;
  } ocs_rate_type;

endpackage // ocs_pkg

/* verilog/ocs_strap_sync.sv */
// Purpose: Three-stage synchroniser for strap pins with agreement filter
// Assumes: Strap levels are quasi-static
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ns

module ocs_strap_sync #(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys, // System clock
  input wire logic [WIDTH-1:0] d, // Asynchronous pin level
  output logic [WIDTH-1:0] q // Filtered level
);
  logic [WIDTH-1:0] s1;
  logic [WIDTH-1:0] s2;
  logic [WIDTH-1:0] s3;

  always_ff @(posedge clk_sys) begin
    s1 <= d;
    s2 <= s1;
    s3 <= s2;
  end

  always_ff @(posedge clk_sys) begin
    if (s2 == s3) begin
      q <= s3;
    end
  end
endmodule // ocs_strap_sync

/* verilog/ocs_top.sv */
// Purpose: Output clock source, divider, APLL rate and DPLL bandwidth selection
// Assumes: Sync ticks come from timing logic on clk_sys; straps are async pins
// Notes: Hold rst for at least five edges so straps settle before capture
`timescale 1ns/1ns

// How it works
// - Output A select bits 3:0; code zero keeps output A low always.
// - Standard A decode: 2k, 8k, digital rates, main and aux dividers.
// - Alternate A decode: main/64, aux dividers, aux reference; rest undefined.
// - Output A alternate-decode bit chooses standard or alternate table.
// - Output B bits 7:4; standard like A but main/2 and undivided main.
// - Alternate B decode: aux, second main dividers, aux reference.
// - Output B alternate-decode bit chooses standard or alternate table.
// - Output A and B select fields reset from their three-bit straps.
// - Frame sync enable bit 6, default set, gates 8 kHz onto its pin.
// - Multiframe sync enable bit 7, default set, gates 2 kHz onto pin.
// - Aux source bit picks aux rate field or main-to-aux rate field.
// - Each APLL runs at four times its selected synthesis rate.
// - Aux rate field decode; zero disables aux APLL, high codes unused.
// - Main-to-aux rate field bits 5:3 decode; 011 and 101 unused.
// - Main rate field bits 2:0 decode into seven synthesis rates; 000 and 001 both give 77.76 MHz.
// - Main and aux rate fields reset from the output straps.
// - Bit 7 sets aux phase detector to measure main against aux.
// - Aux bandwidth: 18, 35, 70 Hz; 011 undefined; resets to 000.
// - Auto switch uses acquisition bandwidth while acquiring, else locked.
// - Two spare bits store and read back with no effect.
// - Main locked bandwidth code decode; 010 undefined; default 35 Hz.
// - Separate alternate-decode bits for A and B reset to zero.
module ocs_top
  import ocs_pkg::*;
(
  input wire logic clk_sys, // System clock, 250 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register offset
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [7:0] reg_rdata, // Read data, valid the cycle after reg_rd
  input wire logic [2:0] output_a_default_strap, // Output A default pins
  input wire logic [2:0] output_b_default_strap, // Output B default pins
  input wire logic frame_tick_8k, // 8 kHz clock from timing logic
  input wire logic multiframe_tick_2k, // 2 kHz clock from timing logic
  input wire logic auto_bandwidth_switch, // Automatic bandwidth switching on
  input wire logic [2:0] main_acquisition_bandwidth, // Acquisition bandwidth code
  input wire logic main_acquiring, // Main DPLL is acquiring lock
  output ocs_sel_type output_clock_a, // Source and divider for output A
  output ocs_sel_type output_clock_b, // Source and divider for output B
  output logic frame_sync_pin, // 8 kHz frame sync pin
  output logic multiframe_sync_pin, // 2 kHz multiframe sync pin
  output ocs_rate_type aux_apll_rate, // Aux APLL rates in kHz
  output ocs_rate_type main_apll_rate, // Main APLL rates in kHz
  output logic aux_measures_main_phase, // Aux detector measures main phase
  output logic [8:0] aux_dpll_bw_hz, // Aux DPLL bandwidth
  output logic [8:0] main_dpll_bw_hz // Main DPLL bandwidth in use
);

  logic [2:0] strap_a;
  logic [2:0] strap_b;
  logic output_a_alt_decode;
  logic output_b_alt_decode;
  logic [3:0] output_a_freq_select;
  logic [3:0] output_b_freq_select;
  logic frame_sync_enable;
  logic multiframe_sync_enable;
  logic [3:0] aux_apll_rate_select;
  logic aux_measures_main;
  logic aux_apll_source_select;
  logic [2:0] main_rate_to_aux_apll;
  logic [2:0] main_apll_rate_select;
  logic [1:0] aux_dpll_bandwidth;
  logic spare_bit_one;
  logic spare_bit_two;
  logic [2:0] main_locked_bandwidth;
  logic [7:0] next_rdata;
  logic [19:0] next_aux_dfs;
  logic [19:0] next_main_dfs;
  ocs_sel_type next_sel_a;
  ocs_sel_type next_sel_b;

  ocs_strap_sync #(.WIDTH(STRAP_WIDTH)) u_strap_a (
    .clk_sys(clk_sys),
    .d(output_a_default_strap),
    .q(strap_a)
  );

  ocs_strap_sync #(.WIDTH(STRAP_WIDTH)) u_strap_b (
    .clk_sys(clk_sys),
    .d(output_b_default_strap),
    .q(strap_b)
  );

  function automatic ocs_sel_type sel(input ocs_src_type s, input logic [6:0] d);
    sel.src = s;
    sel.div = d;
  endfunction

  function automatic ocs_sel_type decode_out(input logic is_b, input logic alt,
                                             input logic [3:0] code);
    decode_out = sel(OC_OFF, 7'h00);
    if (!alt) begin
      case (code)
        4'h1: decode_out = sel(OC_2K, 7'h01);
        4'h2: decode_out = sel(OC_8K, 7'h01);
        4'h3: decode_out = is_b ? sel(OC_MAIN, 7'h02) : sel(OC_DIG_TWO, 7'h01);
        4'h4: decode_out = sel(OC_DIG_ONE, 7'h01);
        4'h5: decode_out = is_b ? sel(OC_MAIN, 7'h01) : sel(OC_MAIN, 7'h30);
        4'h6: decode_out = sel(OC_MAIN, 7'h10);
        4'h7: decode_out = sel(OC_MAIN, 7'h0C);
        4'h8: decode_out = sel(OC_MAIN, 7'h08);
        4'h9: decode_out = sel(OC_MAIN, 7'h06);
        4'hA: decode_out = sel(OC_MAIN, 7'h04);
        4'hB: decode_out = sel(OC_AUX, 7'h40);
        4'hC: decode_out = sel(OC_AUX, 7'h30);
        4'hD: decode_out = sel(OC_AUX, 7'h10);
        4'hE: decode_out = sel(OC_AUX, 7'h08);
        4'hF: decode_out = sel(OC_AUX, 7'h04);
        default: decode_out = sel(OC_OFF, 7'h00);
      endcase
    end else if (!is_b) begin
      case (code)
        4'h1: decode_out = sel(OC_MAIN, 7'h40);
        4'h2: decode_out = sel(OC_AUX, 7'h14);
        4'h3: decode_out = sel(OC_AUX, 7'h0C);
        4'h4: decode_out = sel(OC_AUX, 7'h0A);
        4'h5: decode_out = sel(OC_AUX, 7'h05);
        4'h6: decode_out = sel(OC_AUX, 7'h02);
        4'h7: decode_out = sel(OC_AUX_REF, 7'h01);
        default: decode_out = sel(OC_OFF, 7'h00);
      endcase
    end else begin
      case (code)
        4'h1: decode_out = sel(OC_AUX, 7'h05);
        4'h2: decode_out = sel(OC_AUX, 7'h02);
        4'h3: decode_out = sel(OC_AUX, 7'h01);
        4'h4: decode_out = sel(OC_MAIN_SECOND, 7'h05);
        4'h5: decode_out = sel(OC_MAIN_SECOND, 7'h02);
        4'h6: decode_out = sel(OC_MAIN_SECOND, 7'h01);
        4'h7: decode_out = sel(OC_AUX_REF, 7'h01);
        default: decode_out = sel(OC_OFF, 7'h00);
      endcase
    end
  endfunction

  function automatic logic [19:0] aux_rate(input logic [3:0] code);
    case (code)
      4'h1: aux_rate = RATE_77M760;
      4'h2: aux_rate = RATE_24M576;
      4'h3: aux_rate = RATE_32M768;
      4'h4: aux_rate = RATE_37M056;
      4'h5: aux_rate = RATE_24M704;
      4'h6: aux_rate = RATE_68M736;
      4'h7: aux_rate = RATE_44M736;
      4'h8: aux_rate = RATE_25M248;
      4'h9: aux_rate = RATE_62M500;
      4'hA: aux_rate = RATE_30M720;
      4'hB: aux_rate = RATE_40M000;
      4'hC: aux_rate = RATE_26M000;
      default: aux_rate = RATE_OFF;
    endcase
  endfunction

  function automatic logic [19:0] ft4_rate(input logic [2:0] code);
    case (code)
      3'h0: ft4_rate = RATE_24M576;
      3'h1: ft4_rate = RATE_62M500;
      3'h2: ft4_rate = RATE_32M768;
      3'h4: ft4_rate = RATE_37M056;
      3'h6: ft4_rate = RATE_24M704;
      3'h7: ft4_rate = RATE_25M248;
      default: ft4_rate = RATE_OFF;
    endcase
  endfunction

  function automatic logic [19:0] main_rate(input logic [2:0] code);
    case (code)
      3'h0, 3'h1: main_rate = RATE_77M760;
      3'h2: main_rate = RATE_24M576;
      3'h3: main_rate = RATE_32M768;
      3'h4: main_rate = RATE_37M056;
      3'h5: main_rate = RATE_24M704;
      3'h6: main_rate = RATE_25M248;
      3'h7: main_rate = RATE_62M500;
      default: main_rate = RATE_OFF;
    endcase
  endfunction

  function automatic logic [8:0] main_bw(input logic [2:0] code);
    case (code)
      3'h7, 3'h3: main_bw = BW_18HZ;
      3'h0: main_bw = BW_35HZ;
      3'h1: main_bw = BW_70HZ;
      3'h4: main_bw = BW_120HZ;
      3'h5: main_bw = BW_250HZ;
      3'h6: main_bw = BW_400HZ;
      default: main_bw = BW_NONE;
    endcase
  endfunction

  // Register writes; only documented bits are stored
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      output_a_freq_select <= {1'b0, strap_a};
      output_b_freq_select <= {1'b0, strap_b};
      aux_apll_rate_select <= {1'b0, strap_b};
      main_apll_rate_select <= strap_a;
      output_a_alt_decode <= ALT_RESET;
      output_b_alt_decode <= ALT_RESET;
      frame_sync_enable <= SYNC_EN_RESET[FS_EN_BIT];
      multiframe_sync_enable <= SYNC_EN_RESET[MFS_EN_BIT];
      aux_measures_main <= FLAG_RESET;
      aux_apll_source_select <= FLAG_RESET;
      main_rate_to_aux_apll <= FT4_RESET;
      aux_dpll_bandwidth <= AUX_BW_RESET;
      spare_bit_one <= FLAG_RESET;
      spare_bit_two <= FLAG_RESET;
      main_locked_bandwidth <= LOCKED_BW_RESET;
    end else if (reg_wr) begin
      case (reg_addr)
        ADDR_ALT_DECODE: begin
          output_a_alt_decode <= reg_wdata[ALT_A_BIT];
          output_b_alt_decode <= reg_wdata[ALT_B_BIT];
        end
        ADDR_OUT_A_SEL: output_a_freq_select <= reg_wdata[3:0];
        ADDR_OUT_B_SEL: output_b_freq_select <= reg_wdata[OUT_B_LSB +: 4];
        ADDR_SYNC_EN: begin
          frame_sync_enable <= reg_wdata[FS_EN_BIT];
          multiframe_sync_enable <= reg_wdata[MFS_EN_BIT];
        end
        ADDR_AUX_RATE: aux_apll_rate_select <= reg_wdata[3:0];
        ADDR_MAIN_RATE: begin
          aux_measures_main <= reg_wdata[MEASURE_BIT];
          aux_apll_source_select <= reg_wdata[AUX_SRC_BIT];
          main_rate_to_aux_apll <= reg_wdata[FT4_LSB +: 3];
          main_apll_rate_select <= reg_wdata[2:0];
        end
        ADDR_AUX_BW: aux_dpll_bandwidth <= reg_wdata[1:0];
        ADDR_LOCKED_BW: begin
          spare_bit_one <= reg_wdata[SPARE_ONE_BIT];
          spare_bit_two <= reg_wdata[SPARE_TWO_BIT];
          main_locked_bandwidth <= reg_wdata[2:0];
        end
        default: ;
      endcase
    end
  end

  // Read mux; fixed-zero and unmapped positions return zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      ADDR_ALT_DECODE: begin
        next_rdata[ALT_A_BIT] = output_a_alt_decode;
        next_rdata[ALT_B_BIT] = output_b_alt_decode;
      end
      ADDR_OUT_A_SEL: next_rdata[3:0] = output_a_freq_select;
      ADDR_OUT_B_SEL: next_rdata[OUT_B_LSB +: 4] = output_b_freq_select;
      ADDR_SYNC_EN: begin
        next_rdata[FS_EN_BIT] = frame_sync_enable;
        next_rdata[MFS_EN_BIT] = multiframe_sync_enable;
      end
      ADDR_AUX_RATE: next_rdata[3:0] = aux_apll_rate_select;
      ADDR_MAIN_RATE: begin
        next_rdata[MEASURE_BIT] = aux_measures_main;
        next_rdata[AUX_SRC_BIT] = aux_apll_source_select;
        next_rdata[FT4_LSB +: 3] = main_rate_to_aux_apll;
        next_rdata[2:0] = main_apll_rate_select;
      end
      ADDR_AUX_BW: next_rdata[1:0] = aux_dpll_bandwidth;
      ADDR_LOCKED_BW: begin
        next_rdata[SPARE_ONE_BIT] = spare_bit_one;
        next_rdata[SPARE_TWO_BIT] = spare_bit_two;
        next_rdata[2:0] = main_locked_bandwidth;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Synthesis rates and output selection
  always_comb begin
    next_aux_dfs = aux_apll_source_select ? ft4_rate(main_rate_to_aux_apll)
                                          : aux_rate(aux_apll_rate_select);
    next_main_dfs = main_rate(main_apll_rate_select);
    next_sel_a = decode_out(1'b0, output_a_alt_decode, output_a_freq_select);
    next_sel_b = decode_out(1'b1, output_b_alt_decode, output_b_freq_select);
    // A disabled aux APLL cannot feed an output, so hold it low instead
    if (next_sel_a.src == OC_AUX && next_aux_dfs == RATE_OFF) begin
      next_sel_a = sel(OC_OFF, 7'h00);
    end
    if (next_sel_b.src == OC_AUX && next_aux_dfs == RATE_OFF) begin
      next_sel_b = sel(OC_OFF, 7'h00);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      output_clock_a <= sel(OC_OFF, 7'h00);
      output_clock_b <= sel(OC_OFF, 7'h00);
    end else begin
      output_clock_a <= next_sel_a;
      output_clock_b <= next_sel_b;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aux_apll_rate <= '0;
      main_apll_rate <= '0;
    end else begin
      aux_apll_rate.dfs_khz <= next_aux_dfs;
      aux_apll_rate.apll_khz <= 20'(next_aux_dfs * APLL_MULT);
      main_apll_rate.dfs_khz <= next_main_dfs;
      main_apll_rate.apll_khz <= 20'(next_main_dfs * APLL_MULT);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      frame_sync_pin <= 1'b0;
      multiframe_sync_pin <= 1'b0;
    end else begin
      frame_sync_pin <= frame_sync_enable & frame_tick_8k;
      multiframe_sync_pin <= multiframe_sync_enable & multiframe_tick_2k;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aux_measures_main_phase <= FLAG_RESET;
      aux_dpll_bw_hz <= BW_NONE;
      main_dpll_bw_hz <= BW_NONE;
    end else begin
      aux_measures_main_phase <= aux_measures_main;
      case (aux_dpll_bandwidth)
        2'h0: aux_dpll_bw_hz <= BW_18HZ;
        2'h1: aux_dpll_bw_hz <= BW_35HZ;
        2'h2: aux_dpll_bw_hz <= BW_70HZ;
        default: aux_dpll_bw_hz <= BW_NONE;
      endcase
      main_dpll_bw_hz <= (auto_bandwidth_switch && main_acquiring)
                         ? main_bw(main_acquisition_bandwidth)
                         : main_bw(main_locked_bandwidth);
    end
  end

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  zero_code_a: assert property ((output_a_freq_select == 4'h0) |=>
    (output_clock_a.src == OC_OFF)) else $error("output A not low on code zero");
  std_a_div_a: assert property ((!output_a_alt_decode && output_a_freq_select == 4'h5)
    |=> (output_clock_a.src == OC_MAIN && output_clock_a.div == 7'h30))
    else $error("output A standard code 5 wrong");
  alt_a_ref_a: assert property ((output_a_alt_decode && output_a_freq_select == 4'h7)
    |=> (output_clock_a.src == OC_AUX_REF)) else $error("output A alternate code 7 wrong");
  alt_a_sel_a: assert property ((output_a_alt_decode && output_a_freq_select == 4'h1)
    |=> (output_clock_a.div == 7'h40 && output_clock_a.src == OC_MAIN))
    else $error("output A alternate bit ignored");
  std_b_main_a: assert property ((!output_b_alt_decode && output_b_freq_select == 4'h5)
    |=> (output_clock_b.src == OC_MAIN && output_clock_b.div == 7'h01))
    else $error("output B standard code 5 wrong");
  alt_b_second_a: assert property ((output_b_alt_decode && output_b_freq_select == 4'h4)
    |=> (output_clock_b.src == OC_MAIN_SECOND && output_clock_b.div == 7'h05))
    else $error("output B alternate code 4 wrong");
  frame_sync_pin_gate_a: assert property (!frame_sync_enable [*2] |=> !frame_sync_pin)
    else $error("frame sync pin driven while disabled");
  multiframe_sync_pin_follow_a: assert property ((multiframe_sync_enable && multiframe_tick_2k)
    |=> multiframe_sync_pin) else $error("multiframe sync pin not driven");
  aux_source_a: assert property ((aux_apll_source_select && main_rate_to_aux_apll == 3'h0)
    |=> (aux_apll_rate.dfs_khz == RATE_24M576)) else $error("aux source select wrong");
  apll_times_a: assert property ((main_apll_rate_select == 3'h7) |=>
    (main_apll_rate.apll_khz == 20'(RATE_62M500 * APLL_MULT))) else $error("APLL not 4x");
  aux_bw_a: assert property ((aux_dpll_bandwidth == 2'h2) |=>
    (aux_dpll_bw_hz == BW_70HZ)) else $error("aux bandwidth 70 Hz wrong");
  auto_bw_a: assert property ((!auto_bandwidth_switch && main_locked_bandwidth == 3'h6)
    |=> (main_dpll_bw_hz == BW_400HZ)) else $error("locked bandwidth not used");
  zero_bits_a: assert property ((reg_rd && reg_addr == ADDR_OUT_B_SEL) |=>
    (reg_rdata[3:0] == 4'h0)) else $error("fixed-zero bits read nonzero");

  alt_a_used_c: cover property (output_a_alt_decode && output_clock_a.src == OC_AUX_REF);
  aux_from_main_c: cover property (aux_apll_source_select && aux_apll_rate.dfs_khz != RATE_OFF);
  acquiring_c: cover property (auto_bandwidth_switch && main_acquiring);
  frame_sync_pin_off_c: cover property (!frame_sync_enable ##1 frame_sync_enable);
endmodule // ocs_top
